// file: rxs_pkg.sv
// rxs_pkg: constants, codes and types of the receiver status register bank.
// assumes: imported whole by every design file of the bank.
package rxs_pkg;

   // =====================================================================
   // widths
   localparam int unsigned REG_W    = 8;
   localparam int unsigned ADDR_W   = 6;
   localparam int unsigned STATE_W  = 5;
   localparam int unsigned CNT_W    = 3;

   // =====================================================================
   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_PART_ID  = 6'h30;
   localparam logic [ADDR_W-1:0] ADDR_CHIP_REV = 6'h31;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET   = 6'h32;
   localparam logic [ADDR_W-1:0] ADDR_CRC      = 6'h33;
   localparam logic [ADDR_W-1:0] ADDR_STRENGTH = 6'h34;
   localparam logic [ADDR_W-1:0] ADDR_STATE    = 6'h35;

   // =====================================================================
   // header byte and status bit fields
   localparam int unsigned HDR_RW_BIT    = 7;
   localparam int unsigned HDR_BURST_BIT = 6;
   localparam int unsigned CRC_OK_BIT    = 7;

   // =====================================================================
   // fixed values
   localparam logic [REG_W-1:0] HDR_REPLY      = 8'h00;
   localparam logic [REG_W-1:0] UNMAPPED_VALUE = 8'h00;
   localparam logic [REG_W-1:0] OFFSET_ZERO    = 8'h00;
   localparam logic [REG_W-1:0] ZERO_BYTE      = 8'h00;
   localparam logic [CNT_W-1:0] BIT_FIRST      = 3'h0;
   localparam logic [CNT_W-1:0] BIT_LAST       = 3'h7;
   localparam logic [CNT_W-1:0] BIT_ONE        = 3'h1;

   // =====================================================================
   // radio control state codes
   localparam logic [STATE_W-1:0] ST_SLEEP       = 5'h00;
   localparam logic [STATE_W-1:0] ST_IDLE        = 5'h01;
   localparam logic [STATE_W-1:0] ST_CRYSTAL_OFF = 5'h02;
   localparam logic [STATE_W-1:0] ST_OSC_ON_MC   = 5'h03;
   localparam logic [STATE_W-1:0] ST_REG_ON_MC   = 5'h04;
   localparam logic [STATE_W-1:0] ST_MANUAL_CAL  = 5'h05;
   localparam logic [STATE_W-1:0] ST_OSC_ON_WU   = 5'h06;
   localparam logic [STATE_W-1:0] ST_REG_ON_WU   = 5'h07;
   localparam logic [STATE_W-1:0] ST_CAL_BEGIN   = 5'h08;
   localparam logic [STATE_W-1:0] ST_BW_BOOST    = 5'h09;
   localparam logic [STATE_W-1:0] ST_SYNTH_LOCK  = 5'h0A;
   localparam logic [STATE_W-1:0] ST_IF_STARTUP  = 5'h0B;
   localparam logic [STATE_W-1:0] ST_CAL_FINISH  = 5'h0C;
   localparam logic [STATE_W-1:0] ST_RX          = 5'h0D;
   localparam logic [STATE_W-1:0] ST_RX_END      = 5'h0E;
   localparam logic [STATE_W-1:0] ST_RX_RST      = 5'h0F;
   localparam logic [STATE_W-1:0] ST_RX_OVERFLOW = 5'h11;

   // =====================================================================
   // types
   typedef struct packed {
      logic [REG_W-1:0]   offset;
      logic               crc_ok;
      logic [REG_W-1:0]   strength;
      logic [STATE_W-1:0] state;
   } rxs_stat_s;

   typedef enum logic [1:0] {
      SPI_OFF,
      SPI_HDR,
      SPI_DATA
   } rxs_spi_e;

endpackage : rxs_pkg

// file: rxs_pin_sync.sv
// rxs_pin_sync: three-stage input synchroniser with agreement filter.
// assumes: input is asynchronous to clk; output follows once stages two
// and three agree.
module rxs_pin_sync
   import rxs_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin side
   input  wire logic pin,
   // filtered level
   output logic      level
);

   // =====================================================================
   // stages
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic level_nxt;

   always_comb begin
      level_nxt = level_r;
      if (s2_r == s3_r) begin
         level_nxt = s3_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r    <= RST_VAL;
         s2_r    <= RST_VAL;
         s3_r    <= RST_VAL;
         level_r <= RST_VAL;
      end else begin
         s1_r    <= pin;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;

endmodule // rxs_pin_sync

// file: rxs_status_bank.sv
// rxs_status_bank: read-only status registers behind the serial port.
// assumes: status sources run on REF_CLK; serial pins are asynchronous;
// serial clock is well below REF_CLK / 8.
// Notes on behaviour
// [RULE1] Two read-only bytes give a part identifier and a chip revision value that may change.
// [RULE2] The carrier offset estimate is an 8-bit two's complement value in steps of crystal/2^14.
// [RULE3] The offset estimate reads zero while on-off keying is selected.
// [RULE4] Bit 7 of the checksum status shows the last comparison matched and clears on receive entry; here a same-cycle comparison result wins.
// [RULE5] The signal strength level is an 8-bit read-only value updated by the receiver.
// [RULE6] The radio state register shows the state code in bits 4 to 0 and zeros above.
// [RULE7] State codes follow the fixed table from sleep through receive queue overflow.
// [RULE8] Sleep and crystal-off codes never read back, since chip select low wakes to idle.
// [RULE9] Writes to any status register leave the reported values unchanged.
module rxs_status_bank
   import rxs_pkg::*;
#(
   // arbitrary identity values
   parameter logic [REG_W-1:0] PART_ID  = 8'h5A,
   parameter logic [REG_W-1:0] CHIP_REV = 8'h3C
) (
   // clock and reset
   input  wire logic               REF_CLK,
   input  wire logic               RESETN,
   // serial port pins
   input  wire logic               CHIP_SELECT_N,
   input  wire logic               SCLK,
   input  wire logic               SI,
   output logic                    SO,
   output logic                    SO_OE_N,
   // wake request to control state machine
   output logic                    WAKE_REQ,
   // demodulator
   input  wire logic [REG_W-1:0]   CARRIER_OFFSET_VALUE,
   input  wire logic               OOK_MODE,
   // packet handler
   input  wire logic               CRC_DONE,
   input  wire logic               CRC_MATCH,
   input  wire logic               RX_ENTER,
   // receiver
   input  wire logic [REG_W-1:0]   SIGNAL_STRENGTH_LEVEL,
   // control state machine
   input  wire logic [STATE_W-1:0] RADIO_FSM_STATE_CODE
);

   // =====================================================================
   // pin synchronisers
   logic cs_n_f;
   logic sclk_f;
   logic si_f;

   rxs_pin_sync #(
      .RST_VAL (1'b1)
   ) u_sync_cs (
      .clk     (REF_CLK),
      .rst_n   (RESETN),
      .pin     (CHIP_SELECT_N),
      .level   (cs_n_f)
   );

   rxs_pin_sync #(
      .RST_VAL (1'b0)
   ) u_sync_sclk (
      .clk     (REF_CLK),
      .rst_n   (RESETN),
      .pin     (SCLK),
      .level   (sclk_f)
   );

   rxs_pin_sync #(
      .RST_VAL (1'b0)
   ) u_sync_si (
      .clk     (REF_CLK),
      .rst_n   (RESETN),
      .pin     (SI),
      .level   (si_f)
   );

   // =====================================================================
   // pin edge detection
   logic cs_n_d_r;
   logic cs_n_d_nxt;
   logic sclk_d_r;
   logic sclk_d_nxt;

   always_comb begin
      cs_n_d_nxt = cs_n_f;
      sclk_d_nxt = sclk_f;
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cs_n_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
      end else begin
         cs_n_d_r <= cs_n_d_nxt;
         sclk_d_r <= sclk_d_nxt;
      end
   end

   // =====================================================================
   // state code report
   function automatic logic [STATE_W-1:0] report_state(
      input logic [STATE_W-1:0] code
   );
      logic [STATE_W-1:0] rep;
      rep = code;
      unique case (code)
         ST_SLEEP,
         ST_CRYSTAL_OFF: begin
            rep = ST_IDLE; // RULE8
         end
         ST_IDLE,
         ST_OSC_ON_MC,
         ST_REG_ON_MC,
         ST_MANUAL_CAL,
         ST_OSC_ON_WU,
         ST_REG_ON_WU,
         ST_CAL_BEGIN,
         ST_BW_BOOST,
         ST_SYNTH_LOCK,
         ST_IF_STARTUP,
         ST_CAL_FINISH,
         ST_RX,
         ST_RX_END,
         ST_RX_RST,
         ST_RX_OVERFLOW: begin
            rep = code; // RULE7
         end
         default: begin
            // reserved codes pass through
            rep = code;
         end
      endcase
      return rep;
   endfunction

   // =====================================================================
   // status capture
   rxs_stat_s stat_r;
   rxs_stat_s stat_nxt;

   always_comb begin
      stat_nxt = stat_r;
      // two's complement estimate, crystal/2^14 per step
      stat_nxt.offset = CARRIER_OFFSET_VALUE; // RULE2
      if (OOK_MODE) begin
         stat_nxt.offset = OFFSET_ZERO; // RULE3
      end
      // a comparison result in the same cycle as receive entry wins
      if (CRC_DONE) begin
         stat_nxt.crc_ok = CRC_MATCH; // RULE4
      end else if (RX_ENTER) begin
         stat_nxt.crc_ok = 1'b0; // RULE4
      end
      stat_nxt.strength = SIGNAL_STRENGTH_LEVEL; // RULE5
      // wake on select: sleep and crystal off show as idle
      stat_nxt.state = report_state(RADIO_FSM_STATE_CODE); // RULE7 RULE8
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         stat_r <= '0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // =====================================================================
   // register read mux
   function automatic logic [REG_W-1:0] read_reg(
      input logic [ADDR_W-1:0] addr,
      input rxs_stat_s         st
   );
      logic [REG_W-1:0] val;
      val = UNMAPPED_VALUE;
      unique case (addr)
         ADDR_PART_ID: begin
            val = PART_ID; // RULE1
         end
         ADDR_CHIP_REV: begin
            val = CHIP_REV; // RULE1
         end
         ADDR_OFFSET: begin
            val = st.offset; // RULE2
         end
         ADDR_CRC: begin
            val = ZERO_BYTE;
            val[CRC_OK_BIT] = st.crc_ok; // RULE4
         end
         ADDR_STRENGTH: begin
            val = st.strength; // RULE5
         end
         ADDR_STATE: begin
            val = {{(REG_W-STATE_W){1'b0}}, st.state}; // RULE6
         end
         default: begin
            val = UNMAPPED_VALUE;
         end
      endcase
      return val;
   endfunction

   // =====================================================================
   // serial engine
   rxs_spi_e         spi_st_r;
   rxs_spi_e         spi_st_nxt;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [CNT_W-1:0] bit_cnt_nxt;
   logic [REG_W-1:0] rx_sh_r;
   logic [REG_W-1:0] rx_sh_nxt;
   logic [REG_W-1:0] tx_sh_r;
   logic [REG_W-1:0] tx_sh_nxt;
   logic             so_r;
   logic             so_nxt;
   logic             so_oe_n_r;
   logic             so_oe_n_nxt;
   logic             wake_r;
   logic             wake_nxt;
   logic             cs_fall;
   logic             sclk_rise;
   logic             sclk_fall;
   logic [REG_W-1:0] hdr_byte;

   assign cs_fall   = cs_n_d_r & ~cs_n_f;
   assign sclk_rise = ~sclk_d_r & sclk_f;
   assign sclk_fall = sclk_d_r & ~sclk_f;
   assign hdr_byte  = {rx_sh_r[REG_W-2:0], si_f};

   always_comb begin
      spi_st_nxt  = spi_st_r;
      bit_cnt_nxt = bit_cnt_r;
      rx_sh_nxt   = rx_sh_r;
      tx_sh_nxt   = tx_sh_r;
      so_nxt      = so_r;
      so_oe_n_nxt = so_oe_n_r;
      wake_nxt    = 1'b0;
      unique case (spi_st_r)
         SPI_OFF: begin
            so_oe_n_nxt = 1'b1;
            if (cs_fall) begin
               spi_st_nxt  = SPI_HDR;
               bit_cnt_nxt = BIT_FIRST;
               so_nxt      = HDR_REPLY[REG_W-1];
               tx_sh_nxt   = {HDR_REPLY[REG_W-2:0], 1'b0};
               so_oe_n_nxt = 1'b0;
               wake_nxt    = 1'b1; // RULE8
            end
         end
         SPI_HDR,
         SPI_DATA: begin
            if (cs_n_f) begin
               spi_st_nxt  = SPI_OFF;
               so_oe_n_nxt = 1'b1;
            end else if (sclk_rise) begin
               rx_sh_nxt   = hdr_byte;
               bit_cnt_nxt = bit_cnt_r + BIT_ONE;
               if (bit_cnt_r == BIT_LAST) begin
                  if (spi_st_r == SPI_HDR) begin
                     spi_st_nxt = SPI_DATA;
                     // write data is shifted in and dropped
                     if (hdr_byte[HDR_RW_BIT] && hdr_byte[HDR_BURST_BIT]) begin
                        tx_sh_nxt = read_reg(hdr_byte[ADDR_W-1:0], stat_r);
                     end else begin
                        tx_sh_nxt = UNMAPPED_VALUE; // RULE9
                     end
                  end else begin
                     spi_st_nxt = SPI_HDR;
                     tx_sh_nxt  = HDR_REPLY;
                  end
               end
            end else if (sclk_fall) begin
               so_nxt    = tx_sh_r[REG_W-1];
               tx_sh_nxt = {tx_sh_r[REG_W-2:0], 1'b0};
            end
         end
         default: begin
            spi_st_nxt  = SPI_OFF;
            so_oe_n_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         spi_st_r  <= SPI_OFF;
         bit_cnt_r <= BIT_FIRST;
         rx_sh_r   <= ZERO_BYTE;
         tx_sh_r   <= ZERO_BYTE;
         so_r      <= 1'b0;
         so_oe_n_r <= 1'b1;
         wake_r    <= 1'b0;
      end else begin
         spi_st_r  <= spi_st_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         rx_sh_r   <= rx_sh_nxt;
         tx_sh_r   <= tx_sh_nxt;
         so_r      <= so_nxt;
         so_oe_n_r <= so_oe_n_nxt;
         wake_r    <= wake_nxt;
      end
   end

   // =====================================================================
   // outputs
   assign SO       = so_r;
   assign SO_OE_N  = so_oe_n_r;
   assign WAKE_REQ = wake_r;

endmodule // rxs_status_bank

// file: rxs_status_bank_sva.sv
// rxs_sva: timing checks on the serial port pins of the status bank.
// assumes: bound into rxs_status_bank; one clock, REF_CLK.
module rxs_sva
   import rxs_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // serial port
   input wire logic CHIP_SELECT_N,
   input wire logic SCLK,
   input wire logic SO,
   input wire logic SO_OE_N,
   input wire logic WAKE_REQ
);
   timeunit 1ns;
   timeprecision 1ns;
   // ======================================================================
   // sequences
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);
   sequence sel_held;
      (!CHIP_SELECT_N) [*7];
   endsequence
   sequence desel_held;
      CHIP_SELECT_N [*7];
   endsequence
   // ======================================================================
   // assertions
   wake_pulse_a: assert property (WAKE_REQ |=> !WAKE_REQ)
      else $error("wake pulse longer than one cycle");
   wake_cause_a: assert property ($fell(CHIP_SELECT_N) |-> ##[3:6] WAKE_REQ)
      else $error("no wake after select");
   wake_drive_a: assert property (WAKE_REQ |-> ##[0:2] !SO_OE_N)
      else $error("output not enabled on wake");
   oe_release_a: assert property ($rose(CHIP_SELECT_N) |-> ##[3:6] SO_OE_N)
      else $error("output not released");
   oe_idle_a: assert property (desel_held |-> SO_OE_N)
      else $error("output driven while deselected");
   oe_select_a: assert property (sel_held |-> !SO_OE_N)
      else $error("output not driven while selected");
   so_edge_a: assert property ((!SO_OE_N && !$stable(SO)) |-> !SCLK)
      else $error("data out changed while clock high");
   so_hold_a: assert property (SCLK [*8] |-> $stable(SO))
      else $error("data out moved in high phase");
endmodule // rxs_sva

bind rxs_status_bank rxs_sva u_sva (
   .REF_CLK       (REF_CLK),
   .RESETN        (RESETN),
   .CHIP_SELECT_N (CHIP_SELECT_N),
   .SCLK          (SCLK),
   .SO            (SO),
   .SO_OE_N       (SO_OE_N),
   .WAKE_REQ      (WAKE_REQ)
);

// file: rxs_host_model.sv
// rxs_host_model: host controller driving the serial port.
// assumes: SCLK phases of 8 REF_CLK cycles; SO sampled at SCLK rise.
module rxs_host_model (
   // clock
   input  wire logic clk,
   // serial port
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // released line reads inverted, not the last driven value
   logic so_line;
   assign so_line = so_oe_n ? ~so : so;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ======================================================================
   // one header byte and one data byte
   task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {hdr, wd};
      rd = 8'h00;
      @(posedge clk);
      cs_n <= 1'b0;
      wt(10);
      for (int i = 15; i >= 0; i--) begin
         si <= sh[i];
         wt(8);
         sclk <= 1'b1;
         if (i < 8) rd = {rd[6:0], so_line};
         wt(8);
         sclk <= 1'b0;
      end
      wt(8);
      cs_n <= 1'b1;
      si   <= ~si;
      wt(12);
   endtask
endmodule // rxs_host_model

// file: tb_receiver_status_registers.sv
// tb_receiver_status_registers: reads the status bank through the host model.
// assumes: 50 MHz REF_CLK; status inputs driven on rising edges.
module tb_receiver_status_registers;
   import rxs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // arbitrary identity values
   localparam logic [7:0] ID_P  = 8'h6B;
   localparam logic [7:0] REV_P = 8'h27;
   logic       REF_CLK = 1'b0;
   logic       RESETN  = 1'b0;
   logic       cs_n, sclk, si, so, so_oe_n, wake;
   logic       ook = 1'b0, crc_done = 1'b0, crc_match = 1'b0, rx_enter = 1'b0;
   logic [7:0] offs = 8'h00, lvl = 8'h00, v;
   logic [4:0] fsm = 5'h01;
   int         bad_count = 0, checked = 0, cyc = 0, wakes = 0;
   always #10 REF_CLK = ~REF_CLK;
   rxs_status_bank #(.PART_ID(ID_P), .CHIP_REV(REV_P)) u_dut (
      .REF_CLK               (REF_CLK),
      .RESETN                (RESETN),
      .CHIP_SELECT_N         (cs_n),
      .SCLK                  (sclk),
      .SI                    (si),
      .SO                    (so),
      .SO_OE_N               (so_oe_n),
      .WAKE_REQ              (wake),
      .CARRIER_OFFSET_VALUE  (offs),
      .OOK_MODE              (ook),
      .CRC_DONE              (crc_done),
      .CRC_MATCH             (crc_match),
      .RX_ENTER              (rx_enter),
      .SIGNAL_STRENGTH_LEVEL (lvl),
      .RADIO_FSM_STATE_CODE  (fsm)
   );
   rxs_host_model u_host (.clk(REF_CLK), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
                          .so_oe_n(so_oe_n));
   // ======================================================================
   // checking and verdict
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t read %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      cyc++;
      if (wake === 1'b1) wakes++;
      if (cyc >= 40000) begin
         bad_count++;
         print_verdict();
      end
   end
   task pulse(input logic d, input logic m, input logic r);
      @(posedge REF_CLK);
      crc_done  <= d;
      crc_match <= m;
      rx_enter  <= r;
      @(posedge REF_CLK);
      crc_done <= 1'b0;
      rx_enter <= 1'b0;
   endtask
   // ======================================================================
   // scenarios
   task t_ids;
      int w0;
      w0 = wakes;
      u_host.xfer(8'hF0, 8'h00, v);
      chk(v, ID_P);
      u_host.xfer(8'hF1, 8'h00, v);
      chk(v, REV_P);
      chk(8'(wakes - w0), 8'h02);
   endtask
   task t_offset;
      @(posedge REF_CLK);
      offs <= 8'h9C;
      u_host.xfer(8'hF2, 8'h00, v);
      chk(v, 8'h9C);
      ook <= 1'b1;
      u_host.xfer(8'hF2, 8'h00, v);
      chk(v, 8'h00);
      ook <= 1'b0;
   endtask
   task t_crc;
      pulse(1'b1, 1'b1, 1'b0);
      u_host.xfer(8'hF3, 8'h00, v);
      chk(v, 8'h80);
      pulse(1'b0, 1'b0, 1'b1);
      u_host.xfer(8'hF3, 8'h00, v);
      chk(v, 8'h00);
      pulse(1'b1, 1'b1, 1'b1);
      u_host.xfer(8'hF3, 8'h00, v);
      chk(v, 8'h80);
      pulse(1'b1, 1'b0, 1'b0);
      u_host.xfer(8'hF3, 8'h00, v);
      chk(v, 8'h00);
   endtask
   task t_refuse;
      @(posedge REF_CLK);
      lvl <= 8'hA7;
      u_host.xfer(8'h74, 8'hFF, v);
      chk(v, 8'h00);
      u_host.xfer(8'hF4, 8'h00, v);
      chk(v, 8'hA7);
      u_host.xfer(8'hB4, 8'h00, v);
      chk(v, 8'h00);
      u_host.xfer(8'hF6, 8'h00, v);
      chk(v, 8'h00);
   endtask
   task t_state;
      logic [7:0] e;
      for (int i = 0; i <= 22; i++) begin
         @(posedge REF_CLK);
         fsm <= 5'(i);
         e = (i == 0 || i == 2) ? 8'h01 : 8'(i);
         u_host.xfer(8'hF5, 8'h00, v);
         chk(v, e);
      end
   endtask
   task t_reset;
      @(posedge REF_CLK);
      RESETN <= 1'b0;
      repeat (10) @(posedge REF_CLK);
      RESETN <= 1'b1;
      repeat (5) @(posedge REF_CLK);
      u_host.xfer(8'hF5, 8'h00, v);
      chk(v, 8'h16);
      u_host.xfer(8'hF0, 8'h00, v);
      chk(v, ID_P);
   endtask
   initial begin
      repeat (10) @(posedge REF_CLK);
      RESETN <= 1'b1;
      repeat (5) @(posedge REF_CLK);
      t_ids();
      t_offset();
      t_crc();
      t_refuse();
      t_state();
      t_reset();
      print_verdict();
   end
endmodule // tb_receiver_status_registers
